//--- logic/dhbp_pkg.sv
/*
  Constants and carrier types for the two-channel host bus port.
  Assumes all host pins are already synchronous to clk_sys.
*/
// Summary of operation
// - Three address inputs pick one register within the targeted channel.
// - Eight-bit two-way data bus, host drives on writes, device on reads.
// - Read strobe fall starts read and drives byte; host captures on rise.
// - Write strobe fall starts write; rise stores host byte in register.
// - Access accepted only with chip select low; channel pick decides target.
// - Channel pick low routes to second channel, high to first channel.
// - Broadcast bit zero set in the first channel makes one write update both channels.
`default_nettype none
package dhbp_pkg;
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 3;
    localparam int NUM_CH    = 2;
    localparam int REGS_PER  = 8;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam int BCAST_BIT = 0;
    localparam logic [ADDR_W-1:0] ALT_FN_ADDR = 3'h2;
    localparam int CH_FIRST  = 0;
    localparam int CH_SECOND = 1;

    typedef struct packed {
        logic              cs_n;
        logic              rd_n;
        logic              wr_n;
        logic              pick;
        logic [ADDR_W-1:0] addr;
    } dhbp_ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } dhbp_state_t;
endpackage
`default_nettype wire

//--- logic/dhbp_regbank.sv
/*
  One channel's register set of eight bytes.
  Assumes writes arrive as a one-cycle strobe from the port logic.
*/
`timescale 1ns/1ps
`default_nettype none
module dhbp_regbank (
    input  wire logic                        clk_sys,  // system clock
    input  wire logic                        rst,      // sync reset, high
    input  wire logic                        wr_en,    // one-cycle write
    input  wire logic [dhbp_pkg::ADDR_W-1:0] addr,     // register index
    input  wire logic [dhbp_pkg::DATA_W-1:0] wdata,    // write byte
    output logic      [dhbp_pkg::DATA_W-1:0] rdata,    // selected register
    output logic      [dhbp_pkg::DATA_W-1:0] alt_fn_val // alternate function value
);
    typedef logic [dhbp_pkg::ADDR_W-1:0] dhbp_idx_t;

    logic [dhbp_pkg::DATA_W-1:0] mem_reg [dhbp_pkg::REGS_PER];

    genvar i;
    generate
        for (i = 0; i < dhbp_pkg::REGS_PER; i++) begin : g_reg
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    mem_reg[i] <= dhbp_pkg::REG_RESET;
                end else if (wr_en && addr == dhbp_idx_t'(i)) begin
                    mem_reg[i] <= wdata;
                end
            end
        end
    endgenerate

    assign rdata   = mem_reg[addr];
    assign alt_fn_val = mem_reg[dhbp_pkg::ALT_FN_ADDR];
endmodule
`default_nettype wire

//--- logic/dhbp_port.sv
/*
  Host parallel port for two channels: strobe framing, channel routing,
  broadcast writes and the two-way data bus.
  Assumes host pins are synchronous to clk_sys and stable through a strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module dhbp_port (
    input  wire logic                        clk_sys,          // system clock, 20 MHz
    input  wire logic                        rst,              // sync reset, high
    input  wire logic                        chip_select_n,    // chip select, low
    input  wire logic                        read_strobe_n,    // read strobe, low
    input  wire logic                        write_strobe_n,   // write strobe, low
    input  wire logic                        channel_pick,     // high first, low second
    input  wire logic                        reg_addr_bit2,    // address bit 2
    input  wire logic                        reg_addr_bit1,    // address bit 1
    input  wire logic                        reg_addr_bit0,    // address bit 0
    input  wire logic [dhbp_pkg::DATA_W-1:0] host_data_bus_i,  // bus level in
    output logic      [dhbp_pkg::DATA_W-1:0] host_data_bus_o,  // bus drive value
    output logic                             host_data_bus_oe, // high while driving
    output logic      [dhbp_pkg::NUM_CH-1:0] bcast_active      // broadcast bit per channel
);
    dhbp_pkg::dhbp_ctl_t   ctl;
    dhbp_pkg::dhbp_state_t state_reg;
    dhbp_pkg::dhbp_state_t state_next;
    logic [dhbp_pkg::ADDR_W-1:0] addr_reg;
    logic                        pick_reg;
    logic [dhbp_pkg::DATA_W-1:0] wdata_reg;
    logic [dhbp_pkg::DATA_W-1:0] rdata_reg;
    logic [dhbp_pkg::DATA_W-1:0] ch_rdata [dhbp_pkg::NUM_CH];
    typedef logic [$clog2(dhbp_pkg::NUM_CH)-1:0] dhbp_chidx_t;

    logic [dhbp_pkg::DATA_W-1:0] ch_alt_fn [dhbp_pkg::NUM_CH];
    logic [dhbp_pkg::NUM_CH-1:0] ch_wr;
    logic [dhbp_pkg::ADDR_W-1:0] bank_addr;

    assign ctl = '{cs_n: chip_select_n, rd_n: read_strobe_n, wr_n: write_strobe_n,
                   pick: channel_pick,
                   addr: {reg_addr_bit2, reg_addr_bit1, reg_addr_bit0}};

    wire rd_start = !ctl.cs_n && !ctl.rd_n && ctl.wr_n;
    wire wr_start = !ctl.cs_n && !ctl.wr_n && ctl.rd_n;
    wire rd_end   = (state_reg == dhbp_pkg::ST_READ) && ctl.rd_n;
    wire wr_end   = (state_reg == dhbp_pkg::ST_WRITE) && ctl.wr_n;

    wire [$clog2(dhbp_pkg::NUM_CH)-1:0] live_ch = ctl.pick ? 1'(dhbp_pkg::CH_FIRST) : 1'(dhbp_pkg::CH_SECOND);
    wire [$clog2(dhbp_pkg::NUM_CH)-1:0] held_ch = pick_reg ? 1'(dhbp_pkg::CH_FIRST) : 1'(dhbp_pkg::CH_SECOND);
    // The override bit lives in the first channel's register set.
    wire bcast = ch_alt_fn[dhbp_pkg::CH_FIRST][dhbp_pkg::BCAST_BIT];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dhbp_pkg::ST_IDLE: begin
                if (rd_start) begin
                    state_next = dhbp_pkg::ST_READ;
                end else if (wr_start) begin
                    state_next = dhbp_pkg::ST_WRITE;
                end
            end
            dhbp_pkg::ST_READ: begin
                if (rd_end) begin
                    state_next = dhbp_pkg::ST_IDLE;
                end
            end
            dhbp_pkg::ST_WRITE: begin
                if (wr_end) begin
                    state_next = dhbp_pkg::ST_IDLE;
                end
            end
            default: state_next = dhbp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= dhbp_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Address and pick are latched at the strobe fall so late bus skew cannot retarget.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addr_reg <= '0;
            pick_reg <= 1'b1;
        end else if (state_reg == dhbp_pkg::ST_IDLE && (rd_start || wr_start)) begin
            addr_reg <= ctl.addr;
            pick_reg <= ctl.pick;
        end
    end

    // The byte is taken on every low cycle of the strobe, the falling one included, so that
    // a one-cycle strobe still stores the host's byte and the last level before the rise wins.
    wire wr_take_fall = (state_reg == dhbp_pkg::ST_IDLE) && wr_start;
    wire wr_take_low  = (state_reg == dhbp_pkg::ST_WRITE) && !ctl.wr_n;
    wire wr_take      = wr_take_fall || wr_take_low;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdata_reg <= dhbp_pkg::REG_RESET;
        end else if (wr_take) begin
            wdata_reg <= host_data_bus_i;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg <= dhbp_pkg::REG_RESET;
        end else if (state_reg == dhbp_pkg::ST_IDLE && rd_start) begin
            rdata_reg <= ch_rdata[live_ch];
        end
    end

    // Writes use the index latched at the fall; reads look at the live pins at the fall.
    assign bank_addr = wr_end ? addr_reg : ctl.addr;

    genvar c;
    generate
        for (c = 0; c < dhbp_pkg::NUM_CH; c++) begin : g_ch
            assign ch_wr[c] = wr_end && (bcast || held_ch == dhbp_chidx_t'(c));
            assign bcast_active[c] = ch_alt_fn[c][dhbp_pkg::BCAST_BIT];
            dhbp_regbank u_bank (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .wr_en      (ch_wr[c]),
                .addr       (bank_addr),
                .wdata      (wdata_reg),
                .rdata      (ch_rdata[c]),
                .alt_fn_val (ch_alt_fn[c])
            );
        end
    endgenerate

    assign host_data_bus_o  = rdata_reg;
    assign host_data_bus_oe = (state_reg == dhbp_pkg::ST_READ) && !ctl.rd_n && !ctl.cs_n;
endmodule
`default_nettype wire

//--- bench/dhbp_port_asserts.sv
/* Checker for the host port pins of dhbp_port.
   Assumes the host leaves an idle cycle between accesses. */
`timescale 1ns/1ps
`default_nettype none
module dhbp_port_asserts (
    input wire logic       clk_sys,          // clock
    input wire logic       rst,              // reset
    input wire logic       chip_select_n,    // select
    input wire logic       read_strobe_n,    // read
    input wire logic       write_strobe_n,   // write
    input wire logic [7:0] host_data_bus_o,  // read byte
    input wire logic       host_data_bus_oe, // drive
    input wire logic [1:0] bcast_active      // broadcast
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_RST: assert property (disable iff (1'b0) rst |=> !host_data_bus_oe && bcast_active == 2'h0)
        else $error("reset left outputs set");
    AST_CS: assert property (chip_select_n |-> !host_data_bus_oe)
        else $error("bus driven while unselected");
    AST_RD: assert property (read_strobe_n |-> !host_data_bus_oe)
        else $error("bus driven without read");
    AST_WR: assert property (!write_strobe_n |-> !host_data_bus_oe)
        else $error("bus driven during write");
    AST_START: assert property ($fell(read_strobe_n) && !chip_select_n && write_strobe_n
        ##1 !read_strobe_n && !chip_select_n |-> host_data_bus_oe) else $error("read not answered");
    AST_HOLD: assert property (host_data_bus_oe && $past(host_data_bus_oe) |-> $stable(host_data_bus_o))
        else $error("read byte moved mid strobe");
    AST_ROSE: assert property ($rose(host_data_bus_oe) |-> !$past(read_strobe_n) && !$past(chip_select_n))
        else $error("drive without read start");
    AST_BC: assert property ($changed(bcast_active) |-> !$past(write_strobe_n, 2) || !$past(write_strobe_n, 3))
        else $error("broadcast moved without write");
endmodule
`default_nettype wire
bind dhbp_port dhbp_port_asserts i_chk (.*);

//--- bench/dhbp_host.sv
/* Host-side bus model: resolves the two-way data wire.
   Assumes the bench drives the strobes and the host byte. */
`timescale 1ns/1ps
`default_nettype none
module dhbp_host (
    input  wire logic       clk_sys, // clock
    input  wire logic       h_oe,    // host drives
    input  wire logic [7:0] h_dat,   // host byte
    input  wire logic       d_oe,    // device drives
    input  wire logic [7:0] d_dat,   // device byte
    output logic      [7:0] bus      // wire level
);
    logic [7:0] last_reg = 8'h00;
    // bus resolution
    // No pull-up here, so a released wire toggles rather than hold a stale byte.
    assign bus = d_oe ? d_dat : (h_oe ? h_dat : ~last_reg);
    always_ff @(posedge clk_sys) begin
        last_reg <= bus;
    end
endmodule
`default_nettype wire

//--- bench/dhbp_port_bench.sv
/* Self-checking bench for dhbp_port.
   Assumes the package, port and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dhbp_port_bench;
    logic                clk_sys = 0, rst = 1, h_oe = 0, oe, vo;
    logic          [7:0] h_dat = 0, bus, d_dat, v;
    logic          [1:0] bc;
    logic         [31:0] r;
    dhbp_pkg::dhbp_ctl_t c = 7'h78;
    logic          [7:0] mdl [2][8];
    int                  error_cnt = 0, checked = 0, seed = 82107, cyc = 0, i;
    initial forever #25 clk_sys = ~clk_sys;
    dhbp_port i_dut (.clk_sys(clk_sys), .rst(rst), .chip_select_n(c.cs_n), .read_strobe_n(c.rd_n),
        .write_strobe_n(c.wr_n), .channel_pick(c.pick), .reg_addr_bit2(c.addr[2]), .reg_addr_bit1(c.addr[1]),
        .reg_addr_bit0(c.addr[0]), .host_data_bus_i(bus), .host_data_bus_o(d_dat), .host_data_bus_oe(oe),
        .bcast_active(bc));
    dhbp_host i_host (.clk_sys(clk_sys), .h_oe(h_oe), .h_dat(h_dat), .d_oe(oe), .d_dat(d_dat), .bus(bus));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic int ch(input logic p);
        return p ? dhbp_pkg::CH_FIRST : dhbp_pkg::CH_SECOND;
    endfunction
    // The host holds every pin through the strobe and takes the byte on its rising edge.
    task automatic acc(input logic wr, input logic cs, input logic p, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        c <= {cs, wr, ~wr, p, a};
        h_dat <= d;
        h_oe <= wr;
        repeat (3) @(posedge clk_sys);
        v = bus;
        vo = oe;
        c.rd_n <= 1'b1;
        c.wr_n <= 1'b1;
        @(posedge clk_sys);
        c.cs_n <= 1'b1;
        h_oe <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({7'h0, vo}, {7'h0, !cs && !wr});
    endtask
    task automatic put(input logic cs, input logic p, input logic [2:0] a, input logic [7:0] d);
        logic b;
        b = mdl[0][2][0];
        acc(1, cs, p, a, d);
        for (int k = 0; k < 2; k++) if (!cs && (b || k == ch(p))) mdl[k][a] = d;
        #1 chk({6'h0, bc}, {6'h0, mdl[1][2][0], mdl[0][2][0]});
    endtask
    task automatic get(input logic cs, input logic p, input logic [2:0] a);
        acc(0, cs, p, a, 8'h00);
        if (!cs) chk(v, mdl[ch(p)][a]);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        for (i = 0; i < 16; i++) mdl[i/8][i%8] = dhbp_pkg::REG_RESET;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 16; i++) get(0, i[3], i[2:0]);
        for (i = 0; i < 60; i++) begin
            r = $random(seed);
            put(r[5:4] == 0, r[6], r[2:0], r[15:8]);
            get(r[5:4] == 1, r[7], r[2:0]);
        end
        put(0, 1, 3'h2, 8'h00);
        put(0, 1, 3'h6, 8'h5a);
        put(0, 0, 3'h6, 8'hc3);
        put(0, 1, 3'h2, 8'h01);
        get(0, 0, 3'h6);
        get(0, 1, 3'h6);
        put(1, 0, 3'h5, 8'h3c);
        put(0, 0, 3'h5, 8'h77);
        get(0, 1, 3'h5);
        put(0, 0, 3'h2, 8'h01);
        put(0, 1, 3'h2, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
